// ==== pkg/aetc_pkg.sv ====
// Constants shared by the event-triggered converter control block
package aetc_pkg;
   // Register indexes on the plain register port
   localparam logic [2:0] AETC_IRQ_FLAGS_IDX = 3'h0;
   localparam logic [2:0] AETC_IRQ_EN_IDX    = 3'h1;
   localparam logic [2:0] AETC_IRQ_PRIO_IDX  = 3'h2;
   localparam logic [2:0] AETC_RES_HIGH_IDX  = 3'h3;
   localparam logic [2:0] AETC_RES_LOW_IDX   = 3'h4;
   localparam logic [2:0] AETC_CTRL0_IDX     = 3'h5;
   localparam logic [2:0] AETC_CTRL1_IDX     = 3'h6;
   // Field positions
   localparam int AETC_DONE_BIT   = 6;
   localparam int AETC_GO_BIT     = 2;
   localparam int AETC_PWR_BIT    = 0;
   localparam int AETC_CLKLO_LSB  = 6;
   localparam int AETC_CHAN_LSB   = 3;
   localparam int AETC_JUSTIFY    = 7;
   localparam int AETC_CLKMSB     = 6;
   // Writable masks; unimplemented bits read as zero
   localparam logic [7:0] AETC_CTRL0_MASK = 8'hfd;
   localparam logic [7:0] AETC_CTRL1_MASK = 8'hcf;
   // Reset values
   localparam logic [7:0] AETC_REG_RST    = 8'h00;
   // Compare unit mode that requests a conversion start
   localparam logic [3:0] AETC_MODE_SPECIAL = 4'hb;
   // Conversion timing in bit periods
   localparam int AETC_CONV_TAD    = 12;
   localparam int AETC_RECOVER_TAD = 2;
   // Conversion clock select codes
   localparam logic [2:0] AETC_CS_RC = 3'h3;
   typedef enum logic [2:0] {
      AETC_IDLE    = 3'b001,
      AETC_CONV    = 3'b010,
      AETC_RECOVER = 3'b100
   } aetc_state_t;
endpackage

// ==== design/aetc_conv.sv ====
// Conversion sequencer: bit period divider, 12-period convert, 2-period rest
`timescale 1ns/1ps
module aetc_conv
   import aetc_pkg::*;
#(
   parameter int RC_DIV = 400               // Bit period for internal RC
)(
   input  wire logic       ref_clk,         // Device clock
   input  wire logic       rst_n,           // Async reset, active low
   input  wire logic       go,              // Conversion go flag level
   input  wire logic [2:0] clk_sel,         // Conversion clock select
   input  wire logic [9:0] analog_sample,   // Converter core value
   output logic            sample_hold,     // High while converting
   output logic            done,            // Completion pulse
   output logic [9:0]      result           // Sample captured at done
);
   aetc_state_t state_r, state_nxt;
   logic [15:0] div_r, div_nxt;
   logic [3:0]  tad_r, tad_nxt;
   logic [9:0]  result_r, result_nxt;
   logic        done_r, done_nxt;
   logic [15:0] period;
   logic        tick;

   // Bit period length in device clocks from the select code
   always_comb begin
      unique case (clk_sel)
         3'h0:       period = 16'h0002;
         3'h4:       period = 16'h0004;
         3'h1:       period = 16'h0008;
         3'h5:       period = 16'h0010;
         3'h2:       period = 16'h0020;
         3'h6:       period = 16'h0040;
         AETC_CS_RC: period = 16'(RC_DIV);
         default:    period = 16'h0040;
      endcase
   end

   assign tick = (div_r == period - 16'h0001);

   // Sequencer next state
   always_comb begin
      state_nxt  = state_r;
      div_nxt    = tick ? 16'h0000 : div_r + 16'h0001;
      tad_nxt    = tad_r;
      result_nxt = result_r;
      done_nxt   = 1'b0;
      unique case (state_r)
         AETC_IDLE: begin
            div_nxt = 16'h0000;
            tad_nxt = 4'h0;
            if (go) begin
               state_nxt = AETC_CONV;
            end
         end
         AETC_CONV: begin
            if (!go) begin
               // Aborted: nothing captured
               state_nxt = AETC_RECOVER;
               div_nxt   = 16'h0000;
               tad_nxt   = 4'h0;
            end else if (tick) begin
               tad_nxt = tad_r + 4'h1;
               if (tad_r == 4'(AETC_CONV_TAD - 1)) begin
                  result_nxt = analog_sample;
                  done_nxt   = 1'b1;
                  state_nxt  = AETC_RECOVER;
                  tad_nxt    = 4'h0;
               end
            end
         end
         AETC_RECOVER: begin
            if (tick) begin
               tad_nxt = tad_r + 4'h1;
               if (tad_r == 4'(AETC_RECOVER_TAD - 1)) begin
                  state_nxt = AETC_IDLE;
               end
            end
         end
         default: state_nxt = AETC_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r  <= AETC_IDLE;
         div_r    <= 16'h0000;
         tad_r    <= 4'h0;
         result_r <= 10'h000;
         done_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         div_r    <= div_nxt;
         tad_r    <= tad_nxt;
         result_r <= result_nxt;
         done_r   <= done_nxt;
      end
   end

   assign sample_hold = (state_r == AETC_CONV);
   assign done        = done_r;
   assign result      = result_r;
endmodule

// ==== design/aetc_top.sv ====
// Event-triggered converter control with its software registers
// What this block does
// - Special event starts conversion only when enabled
// - Accepted event sets go, clears timer
// - Powered off: ignore event, still clear timer
// - Unused control bits read zero; results survive all but power-on events
// - Clearing go aborts, result stays unchanged
// - Twelve bit periods, then go clears
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module aetc_top
   import aetc_pkg::*;
#(
   parameter int RC_DIV = 400                 // Bit period for RC source
)(
   input  wire logic       ref_clk,           // Device clock, 100 MHz
   input  wire logic       rst_n,             // Async reset, active low
   input  wire logic [2:0] reg_addr,          // Register index
   input  wire logic [7:0] reg_wdata,         // Write data
   input  wire logic       reg_wr,            // Write strobe
   input  wire logic       reg_rd,            // Read strobe
   output logic [7:0]      reg_rdata,         // Read data, next cycle
   input  wire logic       por_event,         // Power-on or brown-out seen
   input  wire logic       special_event,     // Compare unit event pulse
   input  wire logic [3:0] compare_unit_mode_field, // Compare unit mode
   output logic            timer_clear,       // Clears selected timer
   input  wire logic [9:0] analog_sample,     // Converter core value
   output logic            sample_hold,       // Converter core holding
   output logic [2:0]      input_channel,     // Selected input channel
   output logic [3:0]      port_analog_config, // Port analog config
   output logic            irq_high,          // Request, high priority
   output logic            irq_low            // Request, low priority
);
   logic [7:0] flags_r, flags_nxt;
   logic [7:0] en_r, en_nxt;
   logic [7:0] prio_r, prio_nxt;
   logic [7:0] ctrl0_r, ctrl0_nxt;
   logic [7:0] ctrl1_r, ctrl1_nxt;
   logic [7:0] res_hi_r, res_hi_nxt;
   logic [7:0] res_lo_r, res_lo_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic       timer_clear_r, timer_clear_nxt;
   logic       trig_mode;
   logic       accept;
   logic       conv_done;
   logic [9:0] conv_result;
   logic [2:0] clk_sel;
   logic       wr_ctrl0;
   logic       wr_ctrl1;
   logic       power_on;

   // Power bit, control writes and bit period select
   assign power_on = ctrl0_r[AETC_PWR_BIT];
   assign wr_ctrl0 = reg_wr && (reg_addr == AETC_CTRL0_IDX);
   assign wr_ctrl1 = reg_wr && (reg_addr == AETC_CTRL1_IDX);
   assign clk_sel  = {ctrl1_r[AETC_CLKMSB], ctrl0_r[AETC_CLKLO_LSB +: 2]};

   // Event qualification
   assign trig_mode = (compare_unit_mode_field == AETC_MODE_SPECIAL);
   assign accept    = special_event && trig_mode && power_on;

   // Timer clear follows the event whatever the power bit
   always_comb begin
      timer_clear_nxt = special_event && trig_mode;
   end

   // Timer clear pulse, one cycle after the event
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_clear_r <= 1'b0;
      end else begin
         timer_clear_r <= timer_clear_nxt;
      end
   end

   // Interrupt flag, enable and priority bytes
   always_comb begin
      flags_nxt = flags_r;
      en_nxt    = en_r;
      prio_nxt  = prio_r;
      if (reg_wr && reg_addr == AETC_IRQ_FLAGS_IDX) begin
         flags_nxt = reg_wdata;
      end
      if (reg_wr && reg_addr == AETC_IRQ_EN_IDX) begin
         en_nxt = reg_wdata;
      end
      if (reg_wr && reg_addr == AETC_IRQ_PRIO_IDX) begin
         prio_nxt = reg_wdata;
      end
      // Done flag set wins over a software clear
      if (conv_done) begin
         flags_nxt[AETC_DONE_BIT] = 1'b1;
      end
   end

   // Interrupt registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_r <= AETC_REG_RST;
         en_r    <= AETC_REG_RST;
         prio_r  <= AETC_REG_RST;
      end else begin
         flags_r <= flags_nxt;
         en_r    <= en_nxt;
         prio_r  <= prio_nxt;
      end
   end

   // Control bytes and the go flag
   always_comb begin
      ctrl0_nxt = ctrl0_r;
      ctrl1_nxt = ctrl1_r;
      if (wr_ctrl0) begin
         ctrl0_nxt = reg_wdata & AETC_CTRL0_MASK;
      end
      if (wr_ctrl1) begin
         ctrl1_nxt = reg_wdata & AETC_CTRL1_MASK;
      end
      // Go cannot be set while powered off
      if (wr_ctrl0 && !reg_wdata[AETC_PWR_BIT]) begin
         ctrl0_nxt[AETC_GO_BIT] = 1'b0;
      end
      // Completion ends the conversion
      if (conv_done) begin
         ctrl0_nxt[AETC_GO_BIT] = 1'b0;
      end
      // Accepted event wins over a software clear
      if (accept) begin
         ctrl0_nxt[AETC_GO_BIT] = 1'b1;
      end
   end

   // Control registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl0_r <= AETC_REG_RST;
         ctrl1_r <= AETC_REG_RST;
      end else begin
         ctrl0_r <= ctrl0_nxt;
         ctrl1_r <= ctrl1_nxt;
      end
   end

   // Result pair: loaded on completion, justified per select
   always_comb begin
      res_hi_nxt = res_hi_r;
      res_lo_nxt = res_lo_r;
      if (por_event) begin
         res_hi_nxt = AETC_REG_RST;
         res_lo_nxt = AETC_REG_RST;
      end else if (conv_done) begin
         if (ctrl1_r[AETC_JUSTIFY]) begin
            res_hi_nxt = {6'h00, conv_result[9:8]};
            res_lo_nxt = conv_result[7:0];
         end else begin
            res_hi_nxt = conv_result[9:2];
            res_lo_nxt = {conv_result[1:0], 6'h00};
         end
      end else if (reg_wr && reg_addr == AETC_RES_HIGH_IDX) begin
         res_hi_nxt = reg_wdata;
      end else if (reg_wr && reg_addr == AETC_RES_LOW_IDX) begin
         res_lo_nxt = reg_wdata;
      end
   end

   // No reset here: contents survive all but power-on events
   always_ff @(posedge ref_clk) begin
      res_hi_r <= res_hi_nxt;
      res_lo_r <= res_lo_nxt;
   end

   // Read data, one cycle after the strobe
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            AETC_IRQ_FLAGS_IDX: rdata_nxt = flags_r;
            AETC_IRQ_EN_IDX:    rdata_nxt = en_r;
            AETC_IRQ_PRIO_IDX:  rdata_nxt = prio_r;
            AETC_RES_HIGH_IDX:  rdata_nxt = res_hi_r;
            AETC_RES_LOW_IDX:   rdata_nxt = res_lo_r;
            AETC_CTRL0_IDX:     rdata_nxt = ctrl0_r;
            AETC_CTRL1_IDX:     rdata_nxt = ctrl1_r;
            default:            rdata_nxt = 8'h00;
         endcase
      end
   end

   // Read data register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Conversion sequencer
   aetc_conv #(
      .RC_DIV        (RC_DIV)
   ) u_conv (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .go            (ctrl0_r[AETC_GO_BIT]),
      .clk_sel       (clk_sel),
      .analog_sample (analog_sample),
      .sample_hold   (sample_hold),
      .done          (conv_done),
      .result        (conv_result)
   );

   // Outputs
   assign reg_rdata          = rdata_r;
   assign timer_clear        = timer_clear_r;
   assign input_channel      = ctrl0_r[AETC_CHAN_LSB +: 3];
   assign port_analog_config = ctrl1_r[3:0];
   assign irq_high = flags_r[AETC_DONE_BIT] && en_r[AETC_DONE_BIT]
                     && prio_r[AETC_DONE_BIT];
   assign irq_low  = flags_r[AETC_DONE_BIT] && en_r[AETC_DONE_BIT]
                     && !prio_r[AETC_DONE_BIT];
endmodule

// ==== tb/aetc_ccu_model.sv ====
// Compare unit model with its timer counter
`timescale 1ns/1ps
module aetc_ccu_model #(
   parameter int PERIOD = 200          // Timer match in clocks
)(
   input  wire logic        ref_clk,   // Device clock
   input  wire logic        rst_n,     // Reset, active low
   input  wire logic        run,       // Timer count enable
   input  wire logic [3:0]  mode,      // Mode chosen by bench
   input  wire logic        timer_clear, // Clear from converter
   output logic             special_event, // Match pulse
   output logic [3:0]       mode_field, // Mode seen by converter
   output logic [15:0]      timer_r    // Timer counter
);
   logic [15:0] timer_nxt;
   logic        event_nxt;
   // Count, roll over, obey the converter clear
   always_comb begin
      timer_nxt = run ? timer_r + 16'h1 : timer_r;
      if (timer_r == 16'(2 * PERIOD - 1)) timer_nxt = 16'h0;
      if (timer_clear) timer_nxt = 16'h0;
      event_nxt = run && timer_r == 16'(PERIOD - 1);
   end
   // State registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_r <= 16'h0;
         special_event <= 1'b0;
      end else begin
         timer_r <= timer_nxt;
         special_event <= event_nxt;
      end
   end
   assign mode_field = mode;
endmodule

// ==== tb/aetc_top_chk.sv ====
// Assertion checker for the converter control block
`timescale 1ns/1ps
module aetc_top_chk
   import aetc_pkg::*;
#(
   parameter int RC_DIV = 400          // Bit period for RC source
)(
   input wire logic       ref_clk,     // Device clock
   input wire logic       rst_n,       // Reset, active low
   input wire logic [2:0] reg_addr,    // Register index
   input wire logic [7:0] reg_wdata,   // Write data
   input wire logic       reg_wr,      // Write strobe
   input wire logic       reg_rd,      // Read strobe
   input wire logic [7:0] reg_rdata,   // Read data
   input wire logic       special_event, // Compare unit event
   input wire logic [3:0] compare_unit_mode_field, // Compare mode
   input wire logic       timer_clear, // Timer clear pulse
   input wire logic       sample_hold, // Converting
   input wire logic       irq_high,    // High priority request
   input wire logic       irq_low      // Low priority request
);
   logic        pwr_r, pwr_nxt, cut_r, cut_nxt, ctl_wr, trig;
   logic        en_r, en_nxt, pri_r, pri_nxt, ctl1_wr;
   logic [2:0]  sel_r, sel_nxt;
   logic [15:0] len_r, len_nxt, per;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   assign ctl_wr = reg_wr && reg_addr == AETC_CTRL0_IDX;
   assign trig = special_event && compare_unit_mode_field == AETC_MODE_SPECIAL;
   assign ctl1_wr = reg_wr && reg_addr == AETC_CTRL1_IDX;
   // Track power bit, hold length, software cuts
   always_comb begin
      pwr_nxt = ctl_wr ? reg_wdata[AETC_PWR_BIT] : pwr_r;
      len_nxt = sample_hold ? len_r + 16'h1 : 16'h0;
      cut_nxt = sample_hold && (cut_r || ctl_wr);
      en_nxt  = (reg_wr && reg_addr == AETC_IRQ_EN_IDX)
                ? reg_wdata[AETC_DONE_BIT] : en_r;
      pri_nxt = (reg_wr && reg_addr == AETC_IRQ_PRIO_IDX)
                ? reg_wdata[AETC_DONE_BIT] : pri_r;
      sel_nxt = {ctl1_wr ? reg_wdata[AETC_CLKMSB] : sel_r[2],
                 ctl_wr ? reg_wdata[AETC_CLKLO_LSB +: 2] : sel_r[1:0]};
   end
   // Bit period in clocks for the tracked clock select
   always_comb begin
      unique case (sel_r)
         3'h0:       per = 16'h0002;
         3'h4:       per = 16'h0004;
         3'h1:       per = 16'h0008;
         3'h5:       per = 16'h0010;
         3'h2:       per = 16'h0020;
         3'h6:       per = 16'h0040;
         AETC_CS_RC: per = 16'(RC_DIV);
         default:    per = 16'h0040;
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_r <= 1'b0;
         len_r <= 16'h0;
         cut_r <= 1'b0;
         en_r  <= 1'b0;
         pri_r <= 1'b0;
         sel_r <= 3'h0;
      end else begin
         pwr_r <= pwr_nxt;
         len_r <= len_nxt;
         cut_r <= cut_nxt;
         en_r  <= en_nxt;
         pri_r <= pri_nxt;
         sel_r <= sel_nxt;
      end
   end
   // Start may have to wait out the two-period rest
   sequence s_conv_start;
      ##[2:1000] sample_hold;
   endsequence
   AST_TCLR: assert property (trig |=> timer_clear)
      else $error("timer clear missing after event");
   AST_NO_TCLR: assert property (!trig |=> !timer_clear)
      else $error("timer clear without event");
   AST_START: assert property (trig && pwr_r && !sample_hold && !ctl_wr
      |-> s_conv_start) else $error("event did not start conversion");
   AST_OFF: assert property (trig && !pwr_r && !sample_hold && !ctl_wr
      |=> !sample_hold [*8]) else $error("conversion while powered off");
   AST_ABORT: assert property (sample_hold && ctl_wr && !trig
      && !reg_wdata[AETC_GO_BIT] |-> ##[1:3] !sample_hold)
      else $error("go clear did not abort");
   AST_LEN: assert property ($fell(sample_hold) && !(cut_r || ctl_wr)
      |-> len_r == 16'(AETC_CONV_TAD * per))
      else $error("conversion length wrong");
   AST_UNMAP: assert property (reg_rd && reg_addr == 3'h7
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   AST_RSV: assert property (reg_rd && reg_addr == AETC_CTRL1_IDX
      |=> (reg_rdata & ~AETC_CTRL1_MASK) == 8'h00)
      else $error("unimplemented bits not zero");
   AST_IRQ: assert property (irq_high |-> !irq_low)
      else $error("both interrupt requests high");
   AST_IRQ_SRC: assert property ((irq_high || irq_low)
      |-> en_r && (irq_high == pri_r))
      else $error("request without matching enable");
endmodule
bind aetc_top aetc_top_chk #(.RC_DIV(RC_DIV)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .special_event(special_event),
   .compare_unit_mode_field(compare_unit_mode_field),
   .timer_clear(timer_clear), .sample_hold(sample_hold),
   .irq_high(irq_high), .irq_low(irq_low));

// ==== tb/aetc_top_tb_top.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module aetc_top_tb_top;
   import aetc_pkg::*;
   localparam int RCD = 4;
   logic        ref_clk, rst_n, reg_wr, reg_rd, por_event, run;
   logic        special_event, timer_clear, sample_hold, irq_high, irq_low;
   logic [2:0]  reg_addr, input_channel;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [3:0]  mode, mode_field, port_analog_config;
   logic [9:0]  analog_sample;
   logic [15:0] timer, n, m;
   int          err_count = 0, num_checks = 0, cycles = 0;
   aetc_top #(.RC_DIV(RCD)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_event(por_event),
      .special_event(special_event), .compare_unit_mode_field(mode_field),
      .timer_clear(timer_clear), .analog_sample(analog_sample),
      .sample_hold(sample_hold), .input_channel(input_channel),
      .port_analog_config(port_analog_config), .irq_high(irq_high),
      .irq_low(irq_low));
   aetc_ccu_model #(.PERIOD(200)) u_ccu (.ref_clk(ref_clk), .rst_n(rst_n),
      .run(run), .mode(mode), .timer_clear(timer_clear),
      .special_event(special_event), .mode_field(mode_field), .timer_r(timer));
   task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [2:0] a, logic [15:0] exp, string nm);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(nm, exp, 16'(reg_rdata));
   endtask
   task automatic wait_hold(logic lvl);
      for (int i = 0; i < 500 && sample_hold !== lvl; i++) @(negedge ref_clk);
      chk("hold level", 16'(lvl), 16'(sample_hold));
   endtask
   // Count hold and clear cycles over a window
   task automatic watch(int cyc);
      n = 16'h0;
      m = 16'h0;
      repeat (cyc) begin
         @(negedge ref_clk);
         n = n + 16'(sample_hold);
         m = m + 16'(timer_clear);
      end
   endtask
   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         if (i != 3 && i != 4) rd(3'(i), 0, "reset");
      end
      wr(AETC_CTRL0_IDX, 8'hfb);
      rd(AETC_CTRL0_IDX, 16'hf9, "ctrl0");
      chk("channel", 16'h7, 16'(input_channel));
      wr(AETC_CTRL1_IDX, 8'hff);
      rd(AETC_CTRL1_IDX, 16'hcf, "ctrl1");
      chk("config", 16'hf, 16'(port_analog_config));
      wr(3'h7, 8'hff);
      rd(3'h7, 16'h0, "unmapped");
      wr(AETC_CTRL1_IDX, 8'h00);
      wr(AETC_CTRL0_IDX, 8'hc1);
   endtask
   task automatic t_trigger();
      wr(AETC_IRQ_EN_IDX, 8'h40);
      wr(AETC_IRQ_PRIO_IDX, 8'h40);
      mode <= AETC_MODE_SPECIAL;
      run <= 1'b1;
      wait_hold(1'b1);
      @(posedge ref_clk);
      run <= 1'b0;
      watch(60);
      // First hold cycle was already seen by wait_hold
      chk("hold length", 16'(12 * RCD - 1), n);
      rd(AETC_IRQ_FLAGS_IDX, 16'h40, "done flag");
      rd(AETC_CTRL0_IDX, 16'hc1, "go cleared");
      rd(AETC_RES_HIGH_IDX, 16'hb5, "result high");
      rd(AETC_RES_LOW_IDX, 16'hc0, "result low");
      chk("irq high", 16'h1, 16'(irq_high));
      wr(AETC_IRQ_PRIO_IDX, 8'h00);
      rd(AETC_IRQ_PRIO_IDX, 16'h00, "priority");
      chk("irq low", 16'h1, 16'({irq_high, irq_low}));
      wr(AETC_IRQ_FLAGS_IDX, 8'h00);
      rd(AETC_IRQ_FLAGS_IDX, 16'h00, "flag clear");
      chk("irq off", 16'h0, 16'({irq_high, irq_low}));
   endtask
   task automatic t_modes();
      @(posedge ref_clk);
      mode <= 4'ha;
      run <= 1'b1;
      watch(300);
      chk("wrong mode hold", 16'h0, n);
      chk("wrong mode clear", 16'h0, m);
      wr(AETC_CTRL0_IDX, 8'hc0);
      mode <= AETC_MODE_SPECIAL;
      watch(350);
      chk("off hold", 16'h0, n);
      chk("off clear", 16'h1, m);
      wr(AETC_CTRL0_IDX, 8'hc1);
      analog_sample <= 10'h111;
      wait_hold(1'b1);
      @(posedge ref_clk);
      run <= 1'b0;
      repeat (10) @(posedge ref_clk);
      wr(AETC_CTRL0_IDX, 8'hc1);
      wait_hold(1'b0);
      repeat (4 * RCD) @(posedge ref_clk);
      rd(AETC_RES_HIGH_IDX, 16'hb5, "kept result");
      rd(AETC_IRQ_FLAGS_IDX, 16'h00, "no flag");
   endtask
   task automatic t_resets();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(AETC_RES_HIGH_IDX, 16'hb5, "survives reset");
      @(posedge ref_clk);
      por_event <= 1'b1;
      @(posedge ref_clk);
      por_event <= 1'b0;
      rd(AETC_RES_LOW_IDX, 16'h00, "power-on clear");
   endtask
   // Right justified result at the two-clock bit period
   task automatic t_right();
      wr(AETC_CTRL1_IDX, 8'h80);
      wr(AETC_CTRL0_IDX, 8'h01);
      analog_sample <= 10'h2d7;
      run <= 1'b1;
      wait_hold(1'b1);
      @(posedge ref_clk);
      run <= 1'b0;
      watch(40);
      chk("fast hold length", 16'(12 * 2 - 1), n);
      rd(AETC_RES_HIGH_IDX, 16'h02, "right high");
      rd(AETC_RES_LOW_IDX, 16'hd7, "right low");
      rd(AETC_IRQ_FLAGS_IDX, 16'h40, "fast done flag");
   endtask
   task automatic print_verdict();
      if (err_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      {rst_n, reg_wr, reg_rd, por_event, run} = 5'h0;
      {reg_addr, reg_wdata, mode} = 15'h0;
      analog_sample = 10'h2d7;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_trigger();
      t_modes();
      t_resets();
      t_right();
      print_verdict();
   end
endmodule
